// *** hdl/power_event_pkg.sv ***
// Package with register map, field positions, reset values and timing counts.
package power_event_pkg;

    // Register byte addresses; the low byte 72 is part of each address.
    localparam logic [15:0] ADDR_OUT_LOW       = 16'h7072;
    localparam logic [15:0] ADDR_OUT_HIGH      = 16'h7872;
    localparam logic [15:0] ADDR_IDLE_TIMEOUTS = 16'h8072;
    localparam logic [15:0] ADDR_EVENT_INPUTS  = 16'h8872;
    localparam logic [15:0] ADDR_EVENT_FLAGS   = 16'h9072;
    localparam logic [15:0] ADDR_EVENT_ENABLES = 16'hc872;
    localparam logic [15:0] ADDR_STATE_MIRROR  = 16'hd072;

    // Power-control output bit positions.
    localparam int OUT_CPU_CLK      = 0;
    localparam int OUT_DISPLAY      = 1;
    localparam int OUT_BACKLIGHT    = 2;
    localparam int OUT_LOCAL_ACK    = 3;
    localparam int OUT_LOCAL_ATTN   = 4;
    localparam int OUT_CPU_DOWN     = 5;
    localparam int OUT_GATE_A20     = 6;
    localparam int OUT_FULL_DOWN    = 7;

    // Field positions in the event input, enable and flag registers.
    localparam int INP_UPDATE_BIT   = 15;
    localparam int INP_LOCAL_BIT    = 14;
    localparam int INP_ATTN_GEN_LSB = 8;
    localparam int ENA_NMI_LSB      = 10;
    localparam int ENA_ATTN_LSB     = 2;
    localparam int FLAG_LSB         = 2;
    localparam int LOCAL_REQ_INPUT  = 2;

    // Timeout field special codes.
    localparam logic [7:0] LIMIT_ALWAYS_OFF = 8'h00;
    localparam logic [7:0] LIMIT_ALWAYS_ON  = 8'hff;

    // Reset values.
    localparam logic [15:0] RESET_WORD      = 16'h0000;
    localparam logic [7:0]  RESET_OUT_LOW   = 8'h07;

    // Timing: one idle step is five seconds at a 50 MHz clock.
    localparam int  CLK_HZ          = 50_000_000;
    localparam int  IDLE_STEP_SEC   = 5;
    localparam longint IDLE_STEP_CYCLES = longint'(CLK_HZ) * IDLE_STEP_SEC;
    localparam int  REFRESH_PERIOD_NS = 15_000;
    localparam int  CLK_PERIOD_NS   = 20;
    localparam int  REFRESH_CYCLES  = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

    // Register bus request bundle.
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // Mirror source bundle from the serial and parallel ports.
    typedef struct packed {
        logic [1:0] serial_a_mirror;
        logic [1:0] serial_b_mirror;
        logic [3:0] parallel_ctl_mirror;
        logic [7:0] parallel_data_mirror;
    } mirror_src_t;

endpackage : power_event_pkg

// *** hdl/power_event_monitor.sv ***
// Power-management event monitor: output map, idle timer, event flags and mirror.
//
// Operation
// - Output bits mean clock, display, backlight, handshake, power
// - Idle timeout clears display or backlight output
// - Keyboard interrupt restarts timer at next refresh
// - One shared idle timer serves both timeouts
// - Timer steps five seconds, up to 1270
// - Backlight field: 00 off, FF on, else n*5s
// - Display field: 00 off, FF on, else n*5s
// - Update enable makes output changes strobe latch
// - Local enable turns input 2 into request
// - Attention-generate bits raise attention on transitions
// - Writing zero clears flag, one keeps it
// - Captured input bit frozen while its flag set
// - NMI enables allow NMI on input change
// - Attention enables allow attention per input
// - Inputs 2-6 any edge, 7 rising edge
// - Qualifying change sets flag and NMI; others zero
// - Flag clears when its enables written zero
// - Input register reports eight power inputs
// - Mirror register packs serial and parallel bits
// - Output byte driven on data bus for latch
// - Outputs sit in two registers, low writable in bits 7, 5, 3, 0 only
`timescale 1ns/1ps
module power_event_monitor
    import power_event_pkg::*;
#(
    parameter longint STEP_CYCLES   = IDLE_STEP_CYCLES, // Cycles per five-second idle step.
    parameter int     REFRESH_COUNT = REFRESH_CYCLES    // Cycles between refresh slots.
)(
    input  wire logic        core_clk,             // System clock, 50 MHz.
    input  wire logic        reset,                // Synchronous active-high reset.
    input  wire bus_req_t    bus_req,              // Register bus request.
    output logic [15:0]      rdata,                // Read data, cycle after read strobe.
    input  wire logic [7:0]  power_input_pin,      // External power inputs.
    input  wire logic        keyboard_irq,         // Keyboard interrupt pulse, same domain.
    input  wire logic        gate_a20_in,          // Internal A20 gate, same domain.
    input  wire mirror_src_t mirror_src,           // Port bits shown in the mirror.
    output logic [7:0]       latch_data,           // Output byte for the external latch.
    output logic             latch_strobe,         // One-cycle latch update strobe.
    output logic             attention_signal,     // Attention to keyboard controller.
    output logic             local_request,        // Local access request seen.
    output logic             nmi                   // NMI pulse to the host.
);

    // Elaboration check: counts must be at least one cycle and fit their counters.
    if (STEP_CYCLES < 1 || REFRESH_COUNT < 1 ||
        STEP_CYCLES > 64'h0000_0000_ffff_ffff || REFRESH_COUNT > 32'h0001_0000)
    begin : g_bad_param
        $error("power_event_monitor: counts out of range");
    end

    // All state lives in one packed struct, so reset and registering are one
    // assignment each and no field can be left out of either by mistake.
    typedef struct packed {
        logic [1:0][7:0] sync_reg;       // Two-stage input synchroniser.
        logic [7:0]  prev_reg;           // Previous synchronised sample.
        logic [7:0]  captured_reg;       // Captured inputs, frozen by flags.
        logic [7:0]  out_low_reg;        // Power-control outputs 7:0.
        logic [7:0]  out_high_reg;       // User outputs 15:8.
        logic [15:0] timeouts_reg;       // Backlight and display limits.
        logic [7:0]  inp_ctl_reg;        // Update, local enable, attention generate.
        logic [5:0]  nmi_en_reg;         // NMI enables for inputs 7..2.
        logic [5:0]  attn_en_reg;        // Attention enables for inputs 7..2.
        logic [5:0]  flags_reg;          // Event flags for inputs 7..2.
        logic [31:0] step_cnt_reg;       // Cycles within a five-second step.
        logic [7:0]  idle_steps_reg;     // Shared idle timer in steps.
        logic        kbd_pending_reg;    // Keyboard seen, waiting for refresh.
        logic [15:0] refresh_cnt_reg;    // Refresh slot counter.
        logic        a20_prev_reg;       // Last A20 value for change detect.
        logic [15:0] rdata_reg;          // Registered read data.
        logic [7:0]  latch_data_reg;     // Latch bus value.
        logic        latch_strobe_reg;   // Latch update strobe.
        logic        attn_reg;           // Attention output.
        logic        local_reg;          // Local request output.
        logic        nmi_reg;            // NMI output.
    } state_t;

    state_t state_reg;   // Registered state.
    state_t state_next;  // Next state.

    // Decode for a timeout field: returns 1 when the output should be enabled.
    // One function serves both fields because they share one idle timer;
    // a limit of n keeps the output on while fewer than n steps have passed.
    function automatic logic limit_on(input logic [7:0] limit, input logic [7:0] steps);
        logic on;
        on = 1'b0;
        if (limit == LIMIT_ALWAYS_OFF)
            on = 1'b0;
        else if (limit == LIMIT_ALWAYS_ON)
            on = 1'b1;
        else
            on = (steps < limit);
        return on;
    endfunction : limit_on

    // Synchronised pins and their edges against the previous sample.
    wire logic [7:0] sync_in   = state_reg.sync_reg[1];
    wire logic [7:0] changed   = sync_in ^ state_reg.prev_reg;
    wire logic [7:0] rising    = sync_in & ~state_reg.prev_reg;
    // Qualifying transitions of inputs 7..2; a falling input 7 does not count.
    wire logic [5:0] qual_ev   = {rising[7], changed[6:2]};
    // Any write strobe; the address is decoded in the next-state block.
    wire logic       wr_hit    = bus_req.wr;
    // Counter end points: both counters run from zero to the count less one.
    wire logic       step_done = (state_reg.step_cnt_reg == 32'(STEP_CYCLES - 1));
    wire logic       refresh   = (state_reg.refresh_cnt_reg == 16'(REFRESH_COUNT - 1));

    // Combinational next-state logic. Every field starts from its registered
    // value, so a field that no branch touches simply holds.
    always_comb
    begin
        logic [5:0] events;
        logic [5:0] attn_ev;
        logic [7:0] new_low;
        events     = 6'h00;
        attn_ev    = 6'h00;
        new_low    = 8'h00;
        state_next = state_reg;

        // Synchroniser stages; only stage one feeds stage two. The two flops
        // keep a metastable pin sample away from the edge and flag logic.
        state_next.sync_reg[0] = power_input_pin;
        state_next.sync_reg[1] = state_reg.sync_reg[0];
        state_next.prev_reg    = sync_in;

        // Qualifying transitions: 2..6 any edge, 7 rising only.
        events = qual_ev;
        attn_ev = events & state_reg.attn_en_reg;

        // Default one-cycle pulses. Attention-generate bits act on any change,
        // apart from the attention enables, and the two sources are ORed.
        state_next.nmi_reg          = |(events & state_reg.nmi_en_reg);
        state_next.attn_reg         = (|attn_ev) |
                                      (|(changed[7:2] & state_reg.inp_ctl_reg[5:0]));
        state_next.latch_strobe_reg = 1'b0;

        // Local access request through input 2 when enabled; with the enable
        // clear, input 2 is an ordinary user input.
        state_next.local_reg = state_reg.inp_ctl_reg[INP_LOCAL_BIT - 8] &
                               sync_in[LOCAL_REQ_INPUT];

        // Refresh slot counter. It stands in for the system refresh cycle, the
        // only moment at which a keystroke may restart the idle timer.
        state_next.refresh_cnt_reg = refresh ? 16'h0000 : state_reg.refresh_cnt_reg + 16'h0001;

        // Shared idle timer: tick only while no keyboard activity is pending.
        // A keystroke is parked until the next refresh slot; while it waits
        // the timer neither counts nor restarts, so no timeout fires meanwhile.
        if (keyboard_irq)
            state_next.kbd_pending_reg = 1'b1;
        if (state_reg.kbd_pending_reg && refresh)
        begin
            state_next.kbd_pending_reg = keyboard_irq;
            state_next.step_cnt_reg    = 32'h0000_0000;
            state_next.idle_steps_reg  = 8'h00;
        end
        else if (!state_reg.kbd_pending_reg)
        begin
            // Saturating count; 8 bits of 5 s steps cover 1270 s. It holds
            // at 254, the largest finite limit, so it never wraps back to on.
            if (step_done)
            begin
                state_next.step_cnt_reg = 32'h0000_0000;
                if (state_reg.idle_steps_reg != 8'hfe)
                    state_next.idle_steps_reg = state_reg.idle_steps_reg + 8'h01;
            end
            else
                state_next.step_cnt_reg = state_reg.step_cnt_reg + 32'h0000_0001;
        end

        // Display and backlight follow the one shared timer. The limits are
        // decoded every cycle, so a rewritten limit acts on the next edge.
        new_low = state_reg.out_low_reg;
        new_low[OUT_DISPLAY]   = limit_on(state_reg.timeouts_reg[7:0],
                                          state_reg.idle_steps_reg);
        new_low[OUT_BACKLIGHT] = limit_on(state_reg.timeouts_reg[15:8],
                                          state_reg.idle_steps_reg);
        // A20 and attention are mirrored; a change of either strobes the latch.
        new_low[OUT_GATE_A20]  = gate_a20_in;
        new_low[OUT_LOCAL_ATTN] = state_reg.attn_reg;
        state_next.a20_prev_reg = gate_a20_in;

        // Captured inputs: bits with a set flag stay frozen. Inputs 0 and 1
        // have no flag and always show the synchronised pin.
        state_next.captured_reg[1:0] = sync_in[1:0];
        state_next.captured_reg[7:2] = (state_reg.captured_reg[7:2] & state_reg.flags_reg) |
                                       (sync_in[7:2] & ~state_reg.flags_reg);

        // Register writes. They land on the edge that samples the strobe;
        // unmapped addresses and read-only bits are ignored.
        if (wr_hit)
        begin
            case (bus_req.addr)
                ADDR_OUT_LOW:       new_low[OUT_FULL_DOWN:OUT_LOCAL_ACK] =
                                        {bus_req.wdata[15], new_low[6], bus_req.wdata[13],
                                         new_low[4], bus_req.wdata[11]};
                ADDR_OUT_HIGH:      state_next.out_high_reg = bus_req.wdata[15:8];
                ADDR_IDLE_TIMEOUTS: state_next.timeouts_reg = bus_req.wdata;
                ADDR_EVENT_INPUTS:  state_next.inp_ctl_reg  = bus_req.wdata[15:8];
                ADDR_EVENT_FLAGS:   state_next.flags_reg    = state_reg.flags_reg &
                                                              bus_req.wdata[7:2];
                ADDR_EVENT_ENABLES:
                begin
                    state_next.nmi_en_reg  = bus_req.wdata[15:10];
                    state_next.attn_en_reg = bus_req.wdata[7:2];
                    // Flag drops once neither enable is left.
                    state_next.flags_reg = state_reg.flags_reg &
                                           (bus_req.wdata[15:10] | bus_req.wdata[7:2]);
                end
                default: ;
            endcase
        end
        // CPU clock bit is kept from the write path only.
        if (wr_hit && bus_req.addr == ADDR_OUT_LOW)
            new_low[OUT_CPU_CLK] = bus_req.wdata[8];
        state_next.out_low_reg = new_low;

        // Hardware set wins over a clear in the same cycle, so an event that
        // meets a late clear is never lost.
        state_next.flags_reg = state_next.flags_reg |
                               (events & (state_reg.nmi_en_reg | state_reg.attn_en_reg));

        // Latch update on any change of outputs 7:0 or A20 when enabled. The
        // byte follows the outputs every cycle; the strobe says when to capture.
        state_next.latch_data_reg = state_next.out_low_reg;
        if (state_reg.inp_ctl_reg[INP_UPDATE_BIT - 8] &&
            ((state_next.out_low_reg != state_reg.out_low_reg) ||
             (gate_a20_in != state_reg.a20_prev_reg)))
            state_next.latch_strobe_reg = 1'b1;

        // Read data, one cycle later; unmapped reads return zero.
        state_next.rdata_reg = RESET_WORD;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                ADDR_OUT_LOW:       state_next.rdata_reg = {state_reg.out_low_reg,
                                                            state_reg.out_low_reg};
                ADDR_OUT_HIGH:      state_next.rdata_reg = {state_reg.out_high_reg,
                                                            state_reg.out_high_reg};
                ADDR_IDLE_TIMEOUTS: state_next.rdata_reg = state_reg.timeouts_reg;
                ADDR_EVENT_INPUTS:  state_next.rdata_reg = {state_reg.inp_ctl_reg,
                                                            state_reg.captured_reg};
                ADDR_EVENT_FLAGS:   state_next.rdata_reg = {8'h00, state_reg.flags_reg,
                                                            2'b00};
                // Enables read with the unused bits 9:8 and 1:0 as zero.
                ADDR_EVENT_ENABLES: state_next.rdata_reg = {state_reg.nmi_en_reg, 2'b00,
                                                            state_reg.attn_en_reg, 2'b00};
                ADDR_STATE_MIRROR:  state_next.rdata_reg = mirror_src;
                default:            state_next.rdata_reg = RESET_WORD;
            endcase
        end
    end

    // Register the state; reset loads constants only. Reset sets clock driver,
    // display and backlight on; with the limits at 00, display and backlight drop on the first edge after.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_reg             <= '0;
            state_reg.out_low_reg <= RESET_OUT_LOW;
        end
        else
            state_reg <= state_next;
    end

    // Every output is a field of the registered state, never a gate.
    assign rdata            = state_reg.rdata_reg;
    assign latch_data       = state_reg.latch_data_reg;
    assign latch_strobe     = state_reg.latch_strobe_reg;
    assign attention_signal = state_reg.attn_reg;
    assign local_request    = state_reg.local_reg;
    assign nmi              = state_reg.nmi_reg;

    // Assertions guarding the event and register behaviour.
    // Flag bit k belongs to input k+2; captured bit k to input k.
    sequence s_rise7;
        state_reg.sync_reg[1][7] && !state_reg.prev_reg[7];
    endsequence

    // An enabled rising input 7 gives an NMI and a flag.
    property p_nmi7;
        @(posedge core_clk) disable iff (reset)
        (s_rise7 and state_reg.nmi_en_reg[5]) |=> nmi && state_reg.flags_reg[5];
    endproperty
    a_nmi7: assert property (p_nmi7) else $error("input 7 edge gave no nmi");

    // A lone falling input 7 is no event.
    property p_fall7;
        @(posedge core_clk) disable iff (reset)
        (changed[7] && !rising[7] && !(|(changed[6:2]))) |=> !nmi;
    endproperty
    a_fall7: assert property (p_fall7) else $error("falling input 7 gave nmi");

    // A zero written to flag 0 clears it unless an event meets it.
    property p_clear0;
        @(posedge core_clk) disable iff (reset)
        (bus_req.wr && bus_req.addr == ADDR_EVENT_FLAGS && !bus_req.wdata[2] && !qual_ev[0])
        |=> !state_reg.flags_reg[0];
    endproperty
    a_clear0: assert property (p_clear0) else $error("flag not cleared by zero");

    // No write of ones can set a clear flag.
    property p_keep1;
        @(posedge core_clk) disable iff (reset)
        (!state_reg.flags_reg[1] && !qual_ev[1] && !(bus_req.wr &&
         bus_req.addr == ADDR_EVENT_ENABLES)) |=> !state_reg.flags_reg[1];
    endproperty
    a_keep1: assert property (p_keep1) else $error("flag set without event");

    // Flag 3 freezes captured input 5.
    property p_freeze;
        @(posedge core_clk) disable iff (reset)
        state_reg.flags_reg[3] |=> $stable(state_reg.captured_reg[5]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("captured input moved");

    // Unused flag bits read as zero.
    property p_read_zero;
        @(posedge core_clk) disable iff (reset)
        (bus_req.rd && bus_req.addr == ADDR_EVENT_FLAGS) |=> rdata[15:8] == 8'h00 &&
        rdata[1:0] == 2'b00;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("flag reserved bits set");

    // Two cycles: the limit registers first, then the output follows it.
    property p_off;
        @(posedge core_clk) disable iff (reset)
        (state_reg.timeouts_reg[7:0] == LIMIT_ALWAYS_OFF) |=> ##1
        (!state_reg.out_low_reg[OUT_DISPLAY] || $past(state_reg.timeouts_reg[7:0]) != 8'h00);
    endproperty
    a_off: assert property (p_off) else $error("display on with zero limit");

    // The mirror read shows the port bits of the read cycle.
    property p_mirror;
        @(posedge core_clk) disable iff (reset)
        (bus_req.rd && bus_req.addr == ADDR_STATE_MIRROR) |=> rdata == $past(mirror_src);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror read wrong");

    // With update disabled no latch strobe is given.
    property p_strobe_off;
        @(posedge core_clk) disable iff (reset)
        !state_reg.inp_ctl_reg[7] |=> !latch_strobe;
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("strobe while disabled");

    // The enables read back in place, unused bits zero.
    property p_enables_read;
        @(posedge core_clk) disable iff (reset)
        (bus_req.rd && bus_req.addr == ADDR_EVENT_ENABLES) |=>
        rdata == {$past(state_reg.nmi_en_reg), 2'b00, $past(state_reg.attn_en_reg), 2'b00};
    endproperty
    a_enables_read: assert property (p_enables_read) else $error("enables read wrong");

    // A strobe carries the output byte as it stands.
    property p_latch_byte;
        @(posedge core_clk) disable iff (reset)
        latch_strobe |-> latch_data == state_reg.out_low_reg;
    endproperty
    a_latch_byte: assert property (p_latch_byte) else $error("latch byte stale");

    // With local requests enabled, a high input 2 raises the request.
    property p_local;
        @(posedge core_clk) disable iff (reset)
        (state_reg.inp_ctl_reg[INP_LOCAL_BIT - 8] && sync_in[LOCAL_REQ_INPUT])
        |=> local_request;
    endproperty
    a_local: assert property (p_local) else $error("local request missing");

endmodule : power_event_monitor

// *** verification/host_partner_model.sv ***
// Keyboard controller and host interrupt input seen from the far side of the monitor.
`timescale 1ns/1ps
module host_partner_model
(
    input  wire logic core_clk,         // System clock.
    input  wire logic reset,            // Synchronous reset, active high.
    input  wire logic kbd_req,          // Bench asks for one keystroke.
    input  wire logic nmi,              // Host interrupt pulse.
    input  wire logic attention_signal, // Attention pulse towards the keyboard side.
    output logic      keyboard_irq,     // One-cycle keyboard interrupt.
    output int        nmi_cnt,          // Host interrupts seen.
    output int        attn_cnt          // Attention pulses seen.
);
    // Pulses are counted because each one stands a single cycle and is easily missed.
    always_ff @(posedge core_clk)
    begin
        keyboard_irq <= kbd_req && !keyboard_irq;
        if (reset)
        begin
            nmi_cnt  <= 0;
            attn_cnt <= 0;
        end
        else
        begin
            nmi_cnt  <= nmi_cnt + int'(nmi);
            attn_cnt <= attn_cnt + int'(attention_signal);
        end
    end
endmodule : host_partner_model

// *** verification/tb.sv ***
// Self-checking bench for the power event monitor.
`timescale 1ns/1ps
module tb
    import power_event_pkg::*;
;
    logic        core_clk = 1'b0;     // 50 MHz clock.
    logic        reset    = 1'b1;     // Held for five cycles.
    bus_req_t    bus_req  = '0;       // Register bus request.
    logic [15:0] rdata;               // Read data.
    logic [7:0]  pins     = 8'h00;    // Power inputs.
    logic        gate_a20 = 1'b0;     // Internal A20 level.
    logic        kbd_req  = 1'b0;     // Keystroke request to the partner.
    logic        kbd_irq;             // Keyboard interrupt.
    logic [7:0]  latch_data;          // External latch byte.
    logic        latch_strobe;        // Latch update pulse.
    logic        attn;                // Attention pulse.
    logic        local_request;       // Local access request.
    logic        nmi;                 // Host interrupt.
    int          nmi_cnt;             // Partner's interrupt count.
    int          attn_cnt;            // Partner's attention count.
    int          exp_nmi  = 0;        // Expected interrupts.
    int          exp_attn = 0;        // Expected attention pulses.
    int          error_cnt = 0;       // Mismatches.
    int          checks = 0;          // Comparisons.
    int          n;                   // Wait loop counter.

    always #10 core_clk = ~core_clk;

    // Short step and refresh counts keep the idle timer inside a brief run.
    power_event_monitor #(.STEP_CYCLES(40), .REFRESH_COUNT(4)) u_power_event_monitor (
        .core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
        .power_input_pin(pins), .keyboard_irq(kbd_irq), .gate_a20_in(gate_a20),
        .mirror_src(16'ha5c3), .latch_data(latch_data), .latch_strobe(latch_strobe),
        .attention_signal(attn), .local_request(local_request), .nmi(nmi));

    host_partner_model u_host_partner_model (
        .core_clk(core_clk), .reset(reset), .kbd_req(kbd_req), .nmi(nmi),
        .attention_signal(attn), .keyboard_irq(kbd_irq), .nmi_cnt(nmi_cnt),
        .attn_cnt(attn_cnt));

    task automatic summarize;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req.wr    <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        @(posedge core_clk);
        bus_req.wr    <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is sampled there.
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        bus_req.rd   <= 1'b1;
        bus_req.addr <= a;
        @(posedge core_clk);
        bus_req.rd   <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, rdata);
    endtask : rd

    // Three cycles of synchroniser and edge logic; eight leaves margin.
    task automatic drive_pins(input logic [7:0] v);
        @(posedge core_clk);
        pins <= v;
        repeat (8) @(posedge core_clk);
        chk("nmi count", 16'(exp_nmi), 16'(nmi_cnt));
        chk("attention count", 16'(exp_attn), 16'(attn_cnt));
    endtask : drive_pins

    task automatic key;
        @(posedge core_clk);
        kbd_req <= 1'b1;
        @(posedge core_clk);
        kbd_req <= 1'b0;
    endtask : key

    initial
    begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        summarize();
    end

    initial
    begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_IDLE_TIMEOUTS, 16'h0000);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        rd(ADDR_STATE_MIRROR, 16'ha5c3);
        rd(16'h1234, 16'h0000);
        rd(ADDR_OUT_LOW, 16'h0101);
        wr(ADDR_IDLE_TIMEOUTS, 16'hffff);
        rd(ADDR_OUT_LOW, 16'h0707);
        // Backlight two steps, display four; reads sit mid-step on either side.
        wr(ADDR_IDLE_TIMEOUTS, 16'h0204);
        key();
        repeat (12) @(posedge core_clk);
        rd(ADDR_OUT_LOW, 16'h0707);
        repeat (78) @(posedge core_clk);
        rd(ADDR_OUT_LOW, 16'h0303);
        repeat (78) @(posedge core_clk);
        rd(ADDR_OUT_LOW, 16'h0101);
        wr(ADDR_OUT_HIGH, 16'ha500);
        rd(ADDR_OUT_HIGH, 16'ha5a5);
        wr(ADDR_EVENT_INPUTS, 16'h8000);
        @(posedge core_clk);
        gate_a20 <= 1'b1;
        n = 0;
        while (latch_strobe !== 1'b1 && n < 20)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("latch strobe", 16'h0001, 16'(latch_strobe));
        #1 chk("latch data", 16'h0041, 16'(latch_data));
        wr(ADDR_EVENT_INPUTS, 16'hc000);
        drive_pins(8'h04);
        chk("local request", 16'h0001, 16'(local_request));
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        drive_pins(8'h00);
        wr(ADDR_EVENT_ENABLES, 16'h0800);
        exp_nmi++;
        drive_pins(8'h08);
        rd(ADDR_EVENT_FLAGS, 16'h0008);
        exp_nmi++;
        drive_pins(8'h00);
        rd(ADDR_EVENT_INPUTS, 16'hc008);
        wr(ADDR_EVENT_FLAGS, 16'hffff);
        rd(ADDR_EVENT_FLAGS, 16'h0008);
        wr(ADDR_EVENT_FLAGS, 16'h0000);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        rd(ADDR_EVENT_INPUTS, 16'hc000);
        wr(ADDR_EVENT_ENABLES, 16'h8000);
        exp_nmi++;
        drive_pins(8'h80);
        rd(ADDR_EVENT_FLAGS, 16'h0080);
        wr(ADDR_EVENT_FLAGS, 16'h0000);
        drive_pins(8'h00);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        wr(ADDR_EVENT_ENABLES, 16'h1010);
        exp_nmi++;
        exp_attn++;
        drive_pins(8'h10);
        rd(ADDR_EVENT_ENABLES, 16'h1010);
        wr(ADDR_EVENT_ENABLES, 16'h0010);
        rd(ADDR_EVENT_FLAGS, 16'h0010);
        wr(ADDR_EVENT_ENABLES, 16'h0000);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        wr(ADDR_EVENT_INPUTS, 16'h0800);
        exp_attn++;
        drive_pins(8'h30);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        summarize();
    end
endmodule : tb
